/* File: rcg_pkg.sv */
// Package for the RC CPU clock generator: register map, reset values, timing constants
package rcg_pkg;
   localparam logic [15:0] RCG_CTRL_ADDR      = 16'hFFFB;
   localparam logic [7:0]  RCG_CTRL_RESET     = 8'h02;
   localparam int          RCG_SEL_BIT        = 1;
   localparam int          RCG_SLOW_DIV       = 4;
   localparam int          RCG_DIV_W          = 7;
   localparam int          RCG_STAB_EXP       = 7;
   localparam logic [7:0]  RCG_STAB_CYCLES    = 8'h80;
   localparam logic [2:0]  RCG_SW_UP_CLKS     = 3'h4;
   localparam logic [2:0]  RCG_SW_DN_CLKS     = 3'h2;
   localparam logic [2:0]  RCG_MIN_INSTR_CLKS = 3'h2;

   typedef enum logic [1:0] {
      RCG_ST_OFF,
      RCG_ST_STAB,
      RCG_ST_RUN,
      RCG_ST_STOP
   } rcg_state_t;

   typedef struct packed {
      logic        wr;
      logic        bit_op;
      logic [2:0]  bit_idx;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } rcg_bus_req_t;

   typedef struct packed {
      logic cpu_ce;
      logic instr_ce;
      logic periph_ce;
   } rcg_clk_en_t;
endpackage

/* File: rcg_divider.sv */
// Divider chain on the oscillator clock: counts while run is high, holds its value while run is low
`timescale 1ns/1ps
module rcg_divider (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // Control
   input  wire logic                            run,
   // Divider taps
   output logic [rcg_pkg::RCG_DIV_W-1:0] taps
);
   import rcg_pkg::*;
   logic [RCG_DIV_W-1:0] cnt_r;
   logic [RCG_DIV_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (run) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign taps = cnt_r;
endmodule

/* File: rcg_switch.sv */
// Clock select switch: holds old clock until the old clock has ticked out its latency
`timescale 1ns/1ps
module rcg_switch (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Request and old-clock ticks
   input  wire logic sel_req,
   input  wire logic old_tick,
   input  wire logic phase0,
   // Effective select
   output logic      sel_eff
);
   import rcg_pkg::*;
   logic       sel_r;
   logic       sel_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;

   always_comb begin
      sel_nxt = sel_r;
      cnt_nxt = cnt_r;
      if (sel_req == sel_r) begin
         cnt_nxt = '0;
      end else if (old_tick) begin
         cnt_nxt = cnt_r + 3'h1;
         // Up switch waits 4 old clocks, down switch one instruction (2 clocks)
         if (cnt_nxt >= (sel_r ? RCG_SW_DN_CLKS : RCG_SW_UP_CLKS) && phase0) begin
            sel_nxt = sel_req; // Change only on a divider boundary
            cnt_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_r <= RCG_CTRL_RESET[RCG_SEL_BIT];
         cnt_r <= '0;
      end else begin
         sel_r <= sel_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign sel_eff = sel_r;
endmodule

/* File: rcg_top.sv */
// RC CPU clock generator: control register, oscillator gating, stabilization and clock enables
`timescale 1ns/1ps
module rcg_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Register access
   input  wire logic                 acc_valid,
   input  wire rcg_pkg::rcg_bus_req_t acc_req,
   output logic [7:0]                rdata,
   output logic                      rdata_valid,
   // Standby and wake
   input  wire logic                 stop_cmd,
   input  wire logic                 halt_cmd,
   input  wire logic                 wake,
   // Clock outputs
   output logic                      osc_run,
   output rcg_pkg::rcg_clk_en_t      clk_en,
   output logic [6:0]                periph_taps,
   output logic                      cpu_run,
   output logic                      sel_active
);
   import rcg_pkg::*;

   rcg_state_t           st_r;
   rcg_state_t           st_nxt;
   logic [7:0]           stab_r;
   logic [7:0]           stab_nxt;
   logic                 halt_r;
   logic                 halt_nxt;
   logic [7:0]           ctrl_r;
   logic [7:0]           ctrl_nxt;
   logic [7:0]           rdata_nxt;
   logic                 rdv_nxt;
   rcg_clk_en_t          en_nxt;
   logic                 osc_on;
   logic [RCG_DIV_W-1:0] taps;
   logic                 sel_eff;
   logic                 cpu_tick;
   logic                 phase0;
   logic                 instr_ph_r;
   logic                 instr_ph_nxt;
   logic                 hit;

   assign osc_on = (st_r == RCG_ST_STAB) || (st_r == RCG_ST_RUN);
   assign hit    = acc_valid && (acc_req.addr == RCG_CTRL_ADDR);

   rcg_divider u_div (
      .clk  (clk),
      .rst  (rst),
      .run  (osc_on),
      .taps (taps)
   );

   // Divide by four ticks when the two low taps wrap
   assign phase0   = (taps[1:0] == 2'b11);
   assign cpu_tick = osc_on && (sel_eff ? phase0 : 1'b1);

   rcg_switch u_sw (
      .clk      (clk),
      .rst      (rst),
      .sel_req  (ctrl_r[RCG_SEL_BIT]),
      .old_tick (cpu_tick),
      .phase0   (phase0),
      .sel_eff  (sel_eff)
   );

   // Register file
   always_comb begin
      ctrl_nxt  = ctrl_r;
      rdata_nxt = rdata;
      rdv_nxt   = 1'b0;
      if (hit && acc_req.wr) begin
         if (acc_req.bit_op) begin
            ctrl_nxt[acc_req.bit_idx] = acc_req.wdata[0];
         end else begin
            ctrl_nxt = acc_req.wdata;
         end
      end else if (hit) begin
         rdata_nxt = ctrl_r;
         rdv_nxt   = 1'b1;
      end else if (acc_valid && !acc_req.wr) begin
         rdata_nxt = 8'h00;
      end
   end

   // Power state: off in reset, stabilization, run, stop
   always_comb begin
      st_nxt   = st_r;
      stab_nxt = stab_r;
      halt_nxt = halt_r;
      case (st_r)
         RCG_ST_OFF: begin
            st_nxt   = RCG_ST_STAB;
            stab_nxt = '0;
         end
         RCG_ST_STAB: begin
            stab_nxt = stab_r + 8'h01;
            if (stab_nxt == RCG_STAB_CYCLES) begin
               st_nxt = RCG_ST_RUN;
            end
         end
         RCG_ST_RUN: begin
            if (stop_cmd) begin
               st_nxt   = RCG_ST_STOP;
               halt_nxt = 1'b0;
            end else if (halt_cmd) begin
               halt_nxt = 1'b1;
            end else if (wake) begin
               halt_nxt = 1'b0;
            end
         end
         RCG_ST_STOP: begin
            if (wake) begin
               st_nxt   = RCG_ST_STAB;
               stab_nxt = '0;
            end
         end
         default: begin
            st_nxt = RCG_ST_OFF;
         end
      endcase
   end

   // Clock enables: CPU clock, instruction every two CPU clocks, peripherals
   always_comb begin
      instr_ph_nxt    = instr_ph_r;
      en_nxt.cpu_ce   = 1'b0;
      en_nxt.instr_ce = 1'b0;
      en_nxt.periph_ce = osc_on;
      if (st_r == RCG_ST_RUN && cpu_tick) begin
         en_nxt.cpu_ce = 1'b1;
         instr_ph_nxt  = ~instr_ph_r;
         en_nxt.instr_ce = instr_ph_r && !halt_r;
      end else if (st_r != RCG_ST_RUN) begin
         instr_ph_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r      <= RCG_CTRL_RESET;
         rdata       <= 8'h00;
         rdata_valid <= 1'b0;
         st_r        <= RCG_ST_OFF;
         stab_r      <= '0;
         halt_r      <= 1'b0;
         instr_ph_r  <= 1'b0;
         clk_en      <= '0;
         osc_run     <= 1'b0;
         periph_taps <= '0;
         cpu_run     <= 1'b0;
         sel_active  <= RCG_CTRL_RESET[RCG_SEL_BIT];
      end else begin
         ctrl_r      <= ctrl_nxt;
         rdata       <= rdata_nxt;
         rdata_valid <= rdv_nxt;
         st_r        <= st_nxt;
         stab_r      <= stab_nxt;
         halt_r      <= halt_nxt;
         instr_ph_r  <= instr_ph_nxt;
         clk_en      <= en_nxt;
         osc_run     <= osc_on;
         periph_taps <= taps;
         cpu_run     <= (st_r == RCG_ST_RUN) && !halt_r;
         sel_active  <= sel_eff;
      end
   end
endmodule

/* File: rcg_cpu_model.sv */
// CPU core model: counts instructions from the clock enables
`timescale 1ns/1ps
module rcg_cpu_model (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Enables in, count out
   input  wire rcg_pkg::rcg_clk_en_t en,
   output int                        instr_cnt
);
   import rcg_pkg::*;
   always_ff @(posedge clk) begin
      instr_cnt <= rst ? 0 : instr_cnt + int'(en.instr_ce);
   end
endmodule

/* File: rcg_top_asserts.sv */
// Port checker for the clock generator
`timescale 1ns/1ps
module rcg_top_asserts (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // Register access
   input wire logic                  acc_valid,
   input wire rcg_pkg::rcg_bus_req_t acc_req,
   input wire logic                  rdata_valid,
   // Standby and clocks
   input wire logic                  stop_cmd,
   input wire logic                  halt_cmd,
   input wire logic                  osc_run,
   input wire rcg_pkg::rcg_clk_en_t  clk_en,
   input wire logic [6:0]            periph_taps,
   input wire logic                  cpu_run,
   input wire logic                  sel_active
);
   import rcg_pkg::*;
   logic       rd_q;
   logic [7:0] stab_q;
   always_ff @(posedge clk) begin
      rd_q   <= !rst && acc_valid && !acc_req.wr && acc_req.addr == RCG_CTRL_ADDR;
      stab_q <= (rst || !osc_run) ? 8'h00 : stab_q + {7'h00, stab_q != 8'hFF};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence wr_sel(logic v);
      acc_valid && acc_req.wr && !acc_req.bit_op && acc_req.addr == RCG_CTRL_ADDR && acc_req.wdata[1] == v ##1 cpu_run;
   endsequence
   a_reset_slow_off: assert property ($fell(rst) |-> sel_active && !osc_run && !cpu_run)
      else $error("reset state wrong");
   a_stab_wait: assert property (clk_en.instr_ce |-> stab_q >= 8'h80)
      else $error("ran before stabilization");
   a_slow_period: assert property (clk_en.cpu_ce && sel_active && $past(sel_active) |=>
      (!clk_en.cpu_ce || !sel_active)[*3]) else $error("slow clock too fast");
   a_to_fast: assert property (wr_sel(1'b0) |-> ##[1:24] !sel_active)
      else $error("fast switch late");
   a_to_slow: assert property (wr_sel(1'b1) |-> ##[1:16] sel_active)
      else $error("slow switch late");
   a_read_answer: assert property (rdata_valid == rd_q)
      else $error("read valid wrong");
   a_periph_halt: assert property (!osc_run[*3] |-> !clk_en.periph_ce && $stable(periph_taps))
      else $error("peripheral clock ran");
   a_stop_osc: assert property (stop_cmd && cpu_run |-> ##[1:4] !osc_run)
      else $error("stop ignored");
   a_halt_cpu: assert property (halt_cmd && cpu_run |-> ##[1:4] (!cpu_run && osc_run))
      else $error("halt ignored");
endmodule
bind rcg_top rcg_top_asserts rcg_top_asserts_i (.clk, .rst, .acc_valid, .acc_req, .rdata_valid, .stop_cmd,
   .halt_cmd, .osc_run, .clk_en, .periph_taps, .cpu_run, .sel_active);

/* File: tb_rcg_top.sv */
// Testbench for the clock generator
`timescale 1ns/1ps
module tb_rcg_top;
   import rcg_pkg::*;
   logic         clk, rst, acc_valid, rdata_valid, stop_cmd, halt_cmd, wake, osc_run, cpu_run, sel_active;
   rcg_bus_req_t acc_req;
   rcg_clk_en_t  clk_en;
   logic [7:0]   rdata, e, d;
   logic [6:0]   periph_taps, t;
   logic [31:0]  lfsr;
   int           mismatches, checked, instr_cnt, n, c;
   rcg_top rcg_top_i (.clk, .rst, .acc_valid, .acc_req, .rdata, .rdata_valid, .stop_cmd, .halt_cmd, .wake,
      .osc_run, .clk_en, .periph_taps, .cpu_run, .sel_active);
   rcg_cpu_model rcg_cpu_model_i (.clk, .rst, .en(clk_en), .instr_cnt);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [7:0] exp_ctrl(logic [7:0] o, logic b, logic [7:0] v);
      return b ? {o[7:2], v[0], o[0]} : v;
   endfunction
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int exp_ipc(logic s);
      return s ? 64 / (2 * RCG_SLOW_DIV) : 32;
   endfunction
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cmp1(logic g, logic x, string m);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic cmp8(logic [7:0] g, logic [7:0] x, string m);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic acc(logic w, logic b, logic [15:0] a, logic [7:0] v);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_req   = '{w, b, 3'h1, a, v};
      @(negedge clk);
      acc_valid = 1'b0;
   endtask
   task automatic rd(logic [15:0] a, logic v);
      acc(1'b0, 1'b0, a, 8'h00);
      cmp1(rdata_valid, v, "read valid");
      if (v) cmp8(rdata, e, "read data");
   endtask
   task automatic pulse(int k);
      @(negedge clk);
      halt_cmd = k == 0;
      stop_cmd = k == 1;
      wake     = k == 2;
      @(negedge clk);
      {halt_cmd, stop_cmd, wake} = 3'h0;
   endtask
   task automatic wait_on(logic k, logic v, int lim);
      for (n = 0; (k ? cpu_run : sel_active) !== v; n++) begin
         if (n >= lim) begin
            mismatches++;
            finish_test();
         end
         @(negedge clk);
      end
   endtask
   initial begin
      {mismatches, checked, acc_valid, acc_req, stop_cmd, halt_cmd, wake} = '0;
      lfsr = 32'h61F4;
      rst  = 1'b1;
      e    = RCG_CTRL_RESET;
      repeat (2) @(negedge clk);
      cmp1(osc_run, 1'b0, "osc in reset");
      cmp1(sel_active, 1'b1, "slow in reset");
      rst = 1'b0;
      rd(RCG_CTRL_ADDR, 1'b1);
      wait_on(1'b1, 1'b1, 300);
      cmp1(n + 2 >= 128, 1'b1, "early run");
      cmp1(sel_active, 1'b1, "slow start");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         d    = i == 0 ? 8'h00 : lfsr[8:1] & 8'h02;
         acc(1'b1, 1'b0, RCG_CTRL_ADDR ^ {8'h00, lfsr[15:8] | 8'h01}, lfsr[23:16]);
         acc(1'b1, lfsr[3], RCG_CTRL_ADDR, lfsr[3] ? {7'h00, d[1]} : d);
         e = exp_ctrl(e, lfsr[3], lfsr[3] ? {7'h00, d[1]} : d);
         rd(RCG_CTRL_ADDR, 1'b1);
         rd(RCG_CTRL_ADDR ^ 16'h0100, 1'b0);
         wait_on(1'b0, e[RCG_SEL_BIT], 24);
         c = instr_cnt;
         repeat (64) @(negedge clk);
         cmp1((instr_cnt - c) inside {[exp_ipc(e[1]) - 1 : exp_ipc(e[1])]}, 1'b1, "rate");
      end
      $display("test switch done");
      pulse(0);
      // An instruction enable registered at the halt edge is still counted one edge later
      repeat (2) @(negedge clk);
      c = instr_cnt;
      repeat (16) @(negedge clk);
      cmp1(cpu_run || !osc_run || instr_cnt != c, 1'b0, "halt");
      pulse(2);
      wait_on(1'b1, 1'b1, 20);
      pulse(1);
      repeat (4) @(negedge clk);
      t = periph_taps;
      cmp1(osc_run, 1'b0, "stop");
      repeat (8) @(negedge clk);
      cmp8({1'b0, periph_taps}, {1'b0, t}, "taps ran");
      pulse(2);
      wait_on(1'b1, 1'b1, 300);
      $display("test standby done");
      acc(1'b1, 1'b0, RCG_CTRL_ADDR, 8'h00);
      wait_on(1'b0, 1'b0, 24);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      e   = RCG_CTRL_RESET;
      cmp1(sel_active, 1'b1, "reset slow");
      rd(RCG_CTRL_ADDR, 1'b1);
      $display("test rereset done");
      finish_test();
   end
endmodule
